/* core/usart_clk_pkg.sv */
package usart_clk_pkg;

  // ****************************************************
  // Register map (byte addresses, one 32-bit word each)
  // ****************************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_DATA = 8'h00;
  localparam logic [7:0] OFF_CTRL = 8'h04;
  localparam logic [7:0] OFF_BAUD_LOW = 8'h08;
  localparam logic [7:0] OFF_BAUD_HIGH = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_MASK = 8'h14;

  // ****************************************************
  // Widths, counts and reset values
  // ****************************************************
  localparam int DIV_W = 12;
  localparam int DATA_W = 8;
  localparam int NUM_EV = 6;
  localparam logic [4:0] OS_NORMAL = 5'h10;
  localparam logic [4:0] OS_DOUBLE = 5'h08;
  localparam logic [4:0] OS_SYNC = 5'h02;
  localparam logic [3:0] TX_BITS_PLAIN = 4'h9;
  localparam logic [3:0] TX_BITS_PARITY = 4'ha;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [DIV_W-1:0] DIV_RESET = 12'h000;
  localparam logic [NUM_EV-1:0] EV_RESET = 6'h00;

  // Sticky event bit positions in status and mask
  localparam int ST_TXC = 0;
  localparam int ST_UDRE = 1;
  localparam int ST_RXC = 2;
  localparam int ST_FE = 3;
  localparam int ST_DOR = 4;
  localparam int ST_PE = 5;

  // Control register, bit 0 at the bottom
  typedef struct packed {
    logic parity_odd;
    logic parity_en;
    logic rx_en;
    logic tx_en;
    logic sync_clock_polarity;
    logic xck_direction;
    logic double_speed;
    logic sync_mode_select;
  } ctrl_t;

  // One received character with its error flags
  typedef struct packed {
    logic parity_err;
    logic frame_err;
    logic [DATA_W-1:0] data;
  } rx_entry_t;

  typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SHIFT = 2'b10} tx_state_t;
  typedef enum logic [2:0] {RX_IDLE = 3'b001, RX_START = 3'b010, RX_DATA = 3'b100} rx_state_t;

endpackage

/* core/usart_clk.sv */
`timescale 1ns/1ps
module usart_clk
  import usart_clk_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic xck_in,
  output logic xck_out,
  output logic xck_oe,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic irq
);

  // ****************************************************
  // Helpers
  // ****************************************************
  // States per bit for the given mode; sync ignores double speed
  function automatic logic [4:0] states_per_bit(input ctrl_t c);
    if (c.sync_mode_select) begin
      return OS_SYNC;
    end else if (c.double_speed) begin
      return OS_DOUBLE;
    end
    return OS_NORMAL;
  endfunction

  function automatic logic is_addr(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    return a == off;
  endfunction

  // ****************************************************
  // Register state
  // ****************************************************
  ctrl_t ctrl;
  logic [7:0] baud_divisor_low;
  logic [DIV_W-9:0] baud_divisor_high;
  logic [DIV_W-1:0] baud_divisor;
  logic [NUM_EV-1:0] status;
  logic [NUM_EV-1:0] mask;
  logic [NUM_EV-1:0] ev_set;
  logic wr_done;
  logic rd_done;
  logic [4:0] n_states;
  logic sync_master;
  logic sync_slave;

  assign wr_done = psel && penable && pready && pwrite;
  assign rd_done = psel && penable && pready && !pwrite;
  assign baud_divisor = {baud_divisor_high, baud_divisor_low};
  assign n_states = states_per_bit(ctrl);
  assign sync_master = ctrl.sync_mode_select && ctrl.xck_direction;
  assign sync_slave = ctrl.sync_mode_select && !ctrl.xck_direction;

  // Software writes; high byte only stores, low byte also restarts the counter
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ctrl <= CTRL_RESET;
      baud_divisor_low <= DIV_RESET[7:0];
      baud_divisor_high <= DIV_RESET[DIV_W-1:8];
      mask <= EV_RESET;
    end else if (wr_done) begin
      if (is_addr(paddr, OFF_CTRL)) begin
        ctrl <= pwdata[7:0];
      end
      if (is_addr(paddr, OFF_BAUD_LOW)) begin
        baud_divisor_low <= pwdata[7:0];
      end
      if (is_addr(paddr, OFF_BAUD_HIGH)) begin
        baud_divisor_high <= pwdata[DIV_W-9:0];
      end
      if (is_addr(paddr, OFF_MASK)) begin
        mask <= pwdata[NUM_EV-1:0];
      end
    end
  end

  // ****************************************************
  // Baud rate generator
  // ****************************************************
  logic [DIV_W-1:0] baud_cnt;
  logic baud_tick;
  logic low_written;

  assign low_written = wr_done && is_addr(paddr, OFF_BAUD_LOW);
  assign baud_tick = (baud_cnt == DIV_RESET);

  // Counts down every system clock; period is divisor plus one
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      baud_cnt <= DIV_RESET;
    end else if (low_written) begin
      baud_cnt <= {baud_divisor_high, pwdata[7:0]};
    end else if (baud_tick) begin
      baud_cnt <= baud_divisor;
    end else begin
      baud_cnt <= baud_cnt - 1'b1;
    end
  end

  // ****************************************************
  // Transfer clock: master generation, slave recovery
  // ****************************************************
  logic xck_s1;
  logic xck_s2;
  logic xck_s3;
  logic slave_rise;
  logic slave_fall;
  logic master_change;
  logic master_sample;
  logic sync_change;
  logic sync_sample;

  // Master clock toggles per baud tick, giving the baud rate over two
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      xck_out <= 1'b0;
      xck_oe <= 1'b0;
    end else begin
      xck_oe <= sync_master;
      if (sync_master && baud_tick) begin
        xck_out <= !xck_out;
      end
    end
  end

  // Two-stage synchroniser then an edge detector on the settled copies
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      xck_s1 <= 1'b0;
      xck_s2 <= 1'b0;
      xck_s3 <= 1'b0;
    end else begin
      xck_s1 <= xck_in;
      xck_s2 <= xck_s1;
      xck_s3 <= xck_s2;
    end
  end

  // Pin ignored unless slave; remote must stay under a quarter of sys_clk
  assign slave_rise = sync_slave && xck_s2 && !xck_s3;
  assign slave_fall = sync_slave && !xck_s2 && xck_s3;
  assign master_change = sync_master && baud_tick && (xck_out == ctrl.sync_clock_polarity);
  assign master_sample = sync_master && baud_tick && (xck_out != ctrl.sync_clock_polarity);
  assign sync_change = master_change || (ctrl.sync_clock_polarity ? slave_fall : slave_rise);
  assign sync_sample = master_sample || (ctrl.sync_clock_polarity ? slave_rise : slave_fall);

  // ****************************************************
  // Transmitter clock and shifter
  // ****************************************************
  logic [4:0] tx_div;
  logic tx_tick;
  tx_state_t tx_state;
  logic [DATA_W-1:0] tx_buf;
  logic tx_buf_full;
  logic [9:0] tx_shift;
  logic [3:0] tx_left;
  logic tx_load;
  logic tx_done;
  logic data_write;

  // Async divides baud ticks by 16 or 8; sync uses the change edge
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      tx_div <= 5'h00;
    end else if (ctrl.sync_mode_select) begin
      tx_div <= 5'h00;
    end else if (baud_tick) begin
      tx_div <= (tx_div >= n_states - 5'h01) ? 5'h00 : tx_div + 5'h01;
    end
  end

  assign tx_tick = ctrl.sync_mode_select ? sync_change :
                   (baud_tick && tx_div >= n_states - 5'h01);
  assign data_write = wr_done && is_addr(paddr, OFF_DATA);
  assign tx_load = ctrl.tx_en && tx_tick && tx_buf_full &&
                   (tx_state == TX_IDLE || tx_left == 4'h0);
  assign tx_done = tx_tick && tx_state == TX_SHIFT && tx_left == 4'h0 && !tx_buf_full;

  // Single holding buffer; a write while it is full is dropped
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      tx_buf <= '0;
      tx_buf_full <= 1'b0;
    end else if (tx_load) begin
      tx_buf_full <= 1'b0;
    end else if (data_write && !tx_buf_full) begin
      tx_buf <= pwdata[DATA_W-1:0];
      tx_buf_full <= 1'b1;
    end
  end

  // Frame: start, eight data LSB first, optional parity, one stop
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      tx_state <= TX_IDLE;
      tx_shift <= '1;
      tx_left <= 4'h0;
      serial_out_pin <= 1'b1;
    end else if (tx_load) begin
      tx_state <= TX_SHIFT;
      serial_out_pin <= 1'b0;
      tx_left <= ctrl.parity_en ? TX_BITS_PARITY : TX_BITS_PLAIN;
      tx_shift <= {1'b1, ctrl.parity_en ? (^tx_buf ^ ctrl.parity_odd) : 1'b1, tx_buf};
    end else if (tx_tick && tx_state == TX_SHIFT) begin
      if (tx_left != 4'h0) begin
        serial_out_pin <= tx_shift[0];
        tx_shift <= {1'b1, tx_shift[9:1]};
        tx_left <= tx_left - 4'h1;
      end else begin
        tx_state <= TX_IDLE; // Stop bit finished with nothing waiting
      end
    end
  end

  // ****************************************************
  // Receiver: recovery counter, shifter, two-level buffer
  // ****************************************************
  rx_state_t rx_state;
  logic [4:0] rx_cnt;
  logic [3:0] rx_bit;
  logic [DATA_W-1:0] rx_shift;
  logic rx_par;
  logic rx_point;
  logic rx_store;
  logic [3:0] rx_last;
  rx_entry_t rx_mem [0:1];
  logic rx_wr_ptr;
  logic rx_rd_ptr;
  logic [1:0] rx_count;
  logic rx_pop;
  logic rx_full;
  rx_entry_t rx_new;

  // Async takes a bit once per n_states baud ticks; sync on the sample edge
  assign rx_point = ctrl.sync_mode_select ? sync_sample :
                    (baud_tick && rx_cnt == n_states - 5'h01);
  assign rx_last = ctrl.parity_en ? TX_BITS_PARITY - 4'h1 : TX_BITS_PLAIN - 4'h1;
  assign rx_store = rx_state == RX_DATA && rx_point && rx_bit == rx_last;
  assign rx_full = rx_count[1];
  assign rx_pop = rd_done && is_addr(paddr, OFF_DATA) && rx_count != 2'h0;
  assign rx_new = '{parity_err: ctrl.parity_en && (^rx_shift ^ ctrl.parity_odd ^ rx_par),
                    frame_err: !serial_in_pin, data: rx_shift};

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rx_state <= RX_IDLE;
      rx_cnt <= 5'h00;
      rx_bit <= 4'h0;
      rx_shift <= '0;
      rx_par <= 1'b0;
    end else if (!ctrl.rx_en) begin
      rx_state <= RX_IDLE;
    end else begin
      unique case (rx_state)
        RX_IDLE: begin
          rx_cnt <= 5'h00;
          rx_bit <= 4'h0;
          if (ctrl.sync_mode_select ? (sync_sample && !serial_in_pin) : (baud_tick && !serial_in_pin)) begin
            rx_state <= ctrl.sync_mode_select ? RX_DATA : RX_START;
          end
        end
        RX_START: begin
          // Recheck mid start bit to reject glitches
          if (baud_tick) begin
            rx_cnt <= rx_cnt + 5'h01;
            if (rx_cnt == (n_states >> 1) - 5'h01) begin
              rx_cnt <= 5'h00;
              rx_state <= serial_in_pin ? RX_IDLE : RX_DATA;
            end
          end
        end
        RX_DATA: begin
          if (baud_tick && !ctrl.sync_mode_select) begin
            rx_cnt <= (rx_cnt == n_states - 5'h01) ? 5'h00 : rx_cnt + 5'h01;
          end
          if (rx_point) begin
            rx_bit <= rx_bit + 4'h1;
            if (rx_bit < 4'(DATA_W)) begin
              rx_shift <= {serial_in_pin, rx_shift[DATA_W-1:1]};
            end else if (rx_bit == 4'(DATA_W) && ctrl.parity_en) begin
              rx_par <= serial_in_pin;
            end
            if (rx_store) begin
              rx_state <= RX_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Two-entry buffer; an arrival while full is lost and flagged overrun
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rx_wr_ptr <= 1'b0;
      rx_rd_ptr <= 1'b0;
      rx_count <= 2'h0;
    end else begin
      if (rx_store && !rx_full) begin
        rx_mem[rx_wr_ptr] <= rx_new;
        rx_wr_ptr <= !rx_wr_ptr;
      end
      if (rx_pop) begin
        rx_rd_ptr <= !rx_rd_ptr;
      end
      rx_count <= rx_count + {1'b0, rx_store && !rx_full} - {1'b0, rx_pop};
    end
  end

  // ****************************************************
  // Events and interrupt
  // ****************************************************
  always_comb begin
    ev_set = EV_RESET;
    ev_set[ST_TXC] = tx_done;
    ev_set[ST_UDRE] = tx_load;
    ev_set[ST_RXC] = rx_store && !rx_full;
    ev_set[ST_FE] = rx_store && !rx_full && rx_new.frame_err;
    ev_set[ST_DOR] = rx_store && rx_full;
    ev_set[ST_PE] = rx_store && !rx_full && rx_new.parity_err;
  end

  // Write one clears; a set in the same cycle wins
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      status <= EV_RESET;
    end else if (wr_done && is_addr(paddr, OFF_STATUS)) begin
      status <= (status & ~pwdata[NUM_EV-1:0]) | ev_set;
    end else begin
      status <= status | ev_set;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask);
    end
  end

  // ****************************************************
  // APB slave: answer registered at setup, no further wait
  // ****************************************************
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= '0;
      if (psel && !penable) begin
        unique case (paddr)
          OFF_DATA: prdata <= (rx_count != 2'h0) ? 32'(rx_mem[rx_rd_ptr]) : 32'h0;
          OFF_CTRL: prdata <= 32'(ctrl);
          OFF_BAUD_LOW: prdata <= 32'(baud_divisor_low);
          OFF_BAUD_HIGH: prdata <= 32'(baud_divisor_high);
          OFF_STATUS: prdata <= 32'(status);
          OFF_MASK: prdata <= 32'(mask);
          default: pslverr <= 1'b1; // Unmapped address
        endcase
      end
    end
  end

  // ****************************************************
  // Assertions
  // ****************************************************
  a_baud_reload: assert property (@(posedge sys_clk) disable iff (reset)
    baud_tick && !low_written |=> baud_cnt == $past(baud_divisor)) else $error("baud reload wrong");
  a_low_restart: assert property (@(posedge sys_clk) disable iff (reset)
    low_written |=> baud_cnt == baud_divisor) else $error("low write no reload");
  // Only periods free of low byte writes count, since such a write restarts the count
  a_tick_period: assert property (@(posedge sys_clk) disable iff (reset)
    baud_tick && !low_written && baud_divisor == 12'h002 ##1 !low_written [*2]
    |-> !baud_tick ##1 baud_tick) else $error("baud period wrong");
  a_async_no_xck: assert property (@(posedge sys_clk) disable iff (reset)
    !ctrl.sync_mode_select |=> !xck_oe && !slave_rise && !slave_fall) else $error("pin used in async");
  a_master_drive: assert property (@(posedge sys_clk) disable iff (reset)
    sync_master && $past(sync_master) |-> xck_oe) else $error("master not driving");
  a_slave_delay: assert property (@(posedge sys_clk) disable iff (reset)
    sync_slave [*3] ##0 $rose(xck_s1) |=> slave_rise) else $error("slave edge delay");
  a_sync_tx_edge: assert property (@(posedge sys_clk) disable iff (reset)
    sync_master && !ctrl.sync_clock_polarity && tx_tick |=> $rose(xck_out)) else $error("change edge");
  a_async_tx_div: assert property (@(posedge sys_clk) disable iff (reset)
    !ctrl.sync_mode_select && tx_tick |-> baud_tick && tx_div == n_states - 5'h01) else $error("tx div");
  a_overrun: assert property (@(posedge sys_clk) disable iff (reset)
    rx_store && rx_full |=> status[ST_DOR] && rx_count == 2'h2 - {1'b0, $past(rx_pop)}) else $error("overrun");
  a_irq_level: assert property (@(posedge sys_clk) disable iff (reset)
    ev_set[ST_RXC] && mask[ST_RXC] |-> ##2 irq) else $error("irq missing");
  c_async_double: cover property (@(posedge sys_clk) disable iff (reset)
    ctrl.double_speed && !ctrl.sync_mode_select && rx_store);
  c_master_done: cover property (@(posedge sys_clk) disable iff (reset) sync_master && tx_done);
  c_slave_rx: cover property (@(posedge sys_clk) disable iff (reset) sync_slave && rx_store);
  c_back_to_back: cover property (@(posedge sys_clk) disable iff (reset) tx_load && tx_state == TX_SHIFT);

endmodule

/* tb/serial_peer.sv */
`timescale 1ns/1ps
// ****************************************************
// Remote serial transceiver on the data and clock lines
// ****************************************************
module serial_peer (
  input wire logic sys_clk,
  input wire logic line_in,
  output logic line_out,
  output logic xck
);
  int cyc = 0;
  int bit_len = 48;
  bit rx_on = 1'b0;
  logic [7:0] rx_q[$];
  int stamp_q[$];
  logic [7:0] sh;

  // Data idles high; the clock stands still between frames
  initial begin
    line_out = 1'b1;
    xck = 1'b0;
  end

  // Free cycle count used to stamp frame starts
  always @(posedge sys_clk) cyc++;

  // Async receiver: centre sampling after each start edge
  always begin
    @(negedge line_in iff rx_on);
    stamp_q.push_back(cyc);
    repeat (bit_len / 2) @(posedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_len) @(posedge sys_clk);
      sh[i] = line_in;
    end
    repeat (bit_len) @(posedge sys_clk);
    rx_q.push_back(sh);
  end

  // Async frame, LSB first; a low stop bit only when asked for
  // With parity on, the receiver reads the stop slot as parity and the idle bit as stop
  task automatic send_async(input logic [7:0] b, input bit bad_stop);
    logic [9:0] f;
    f = {~bad_stop, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_out <= f[i];
      repeat (bit_len) @(posedge sys_clk);
    end
    line_out <= 1'b1;
    repeat (bit_len) @(posedge sys_clk);
  endtask

  // Sync slave frame: leading edge changes data, trailing edge samples
  task automatic sync_xfer(input bit pol, input logic [7:0] b, output logic [7:0] got);
    logic [13:0] f;
    logic [13:0] smp;
    int k;
    f = {4'hf, b, 2'b01};
    xck <= pol;
    repeat (8) @(posedge sys_clk);
    for (int i = 0; i < 14; i++) begin
      xck <= ~pol;
      line_out <= f[i];
      repeat (4) @(posedge sys_clk);
      xck <= pol;
      smp[i] = line_in;
      repeat (4) @(posedge sys_clk);
    end
    k = 0;
    while (k < 5 && smp[k] !== 1'b0) k++;
    got = smp[k + 1 +: 8];
  endtask
endmodule

/* tb/usart_clk_test.sv */
`timescale 1ns/1ps
module usart_clk_test
  import usart_clk_pkg::*;
();
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, xck_in, xck_out, xck_oe, serial_in_pin, serial_out_pin, irq, peer_xck;
  int err_count = 0;
  int samples_checked = 0;
  logic [31:0] rd;
  logic eb;
  logic [7:0] got;
  int mul, t0;

  // Pin level: the driving side wins, the peer clock otherwise
  assign xck_in = xck_oe ? xck_out : peer_xck;

  usart_clk DUT (.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .xck_in(xck_in), .xck_out(xck_out), .xck_oe(xck_oe), .serial_in_pin(serial_in_pin),
    .serial_out_pin(serial_out_pin), .irq(irq));

  serial_peer PEER (.sys_clk(sys_clk), .line_in(serial_out_pin), .line_out(serial_in_pin), .xck(peer_xck));

  // 25 MHz system clock
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end

  // ****************************************************
  // Compare, bus and helper tasks
  // ****************************************************
  task automatic chk32(input logic [31:0] g, input logic [31:0] e, input string m);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic chk1(input logic g, input logic e, input string m);
    chk32({31'h0, g}, {31'h0, e}, m);
  endtask

  // One APB transfer; waits for pready, never assumes a latency
  task automatic apb(input bit w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic er);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    q = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic x;
    apb(1'b1, a, d, rd, x);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string m);
    logic x;
    apb(1'b0, a, 32'h0, rd, x);
    chk32(rd, e, m);
  endtask

  // High byte first: the low byte write reloads the counter
  task automatic set_div(input logic [11:0] d);
    wr(OFF_BAUD_HIGH, {28'h0, d[11:8]});
    wr(OFF_BAUD_LOW, {24'h0, d[7:0]});
  endtask

  task automatic poll(input int b);
    for (int i = 0; i < 500; i++) begin
      apb(1'b0, OFF_STATUS, 32'h0, rd, eb);
      if (rd[b] === 1'b1) break;
    end
  endtask

  // Cycles until the master clock pin next changes
  task automatic edge_gap(output int n);
    logic v;
    v = xck_out;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (xck_out === v && n < 1000);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Watchdog: the tests need well under this span
  initial begin
    #(40 * 60000);
    err_count++;
    test_done();
  end

  // ****************************************************
  // Test sequence
  // ****************************************************
  initial begin
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    for (int i = 1; i < 6; i++) rdc(8'(4 * i), 32'h0, "reset value");
    apb(1'b0, 8'h18, 32'h0, rd, eb);
    chk1(eb, 1'b1, "unmapped error");
    chk32(rd, 32'h0, "unmapped data");
    chk1(xck_oe, 1'b0, "pin idle after reset");
    $display("test reset done");
    // Both async modes: rate, back-to-back frames, events, receive
    for (int m = 0; m < 2; m++) begin
      mul = m ? 8 : 16;
      set_div(12'h002);
      wr(OFF_CTRL, m ? 32'h32 : 32'h30);
      PEER.bit_len = mul * 3;
      PEER.rx_on = 1'b1;
      PEER.rx_q.delete();
      PEER.stamp_q.delete();
      wr(OFF_DATA, 32'ha5);
      poll(ST_UDRE);
      wr(OFF_DATA, 32'h3c);
      for (int i = 0; i < 5000 && PEER.rx_q.size() < 2; i++) @(posedge sys_clk);
      chk32({24'h0, PEER.rx_q[0]}, 32'ha5, "tx first byte");
      chk32({24'h0, PEER.rx_q[1]}, 32'h3c, "tx second byte");
      chk32(PEER.stamp_q[1] - PEER.stamp_q[0], 30 * mul, "frame spacing");
      chk1(xck_oe, 1'b0, "async pin unused");
      repeat (mul * 3 + 4) @(posedge sys_clk);
      rdc(OFF_STATUS, 32'h03, "tx events");
      chk1(irq, 1'b0, "masked irq");
      wr(OFF_MASK, 32'h01);
      repeat (2) @(posedge sys_clk);
      chk1(irq, 1'b1, "unmasked irq");
      wr(OFF_STATUS, 32'h01);
      repeat (2) @(posedge sys_clk);
      chk1(irq, 1'b0, "irq after clear");
      wr(OFF_MASK, 32'h04);
      wr(OFF_STATUS, 32'h3f);
      PEER.send_async(8'h5a, 1'b0);
      rdc(OFF_STATUS, 32'h04, "rx event");
      chk1(irq, 1'b1, "rx irq");
      rdc(OFF_DATA, 32'h5a, "rx byte");
      wr(OFF_STATUS, 32'h3f);
      $display("test async mode %0d done", m);
    end
    // Two-level buffer overrun, then a frame error
    wr(OFF_CTRL, 32'h30);
    PEER.bit_len = 48;
    for (int i = 0; i < 3; i++) PEER.send_async(8'(8'h11 * (i + 1)), 1'b0);
    rdc(OFF_STATUS, 32'h14, "overrun event");
    rdc(OFF_DATA, 32'h11, "oldest byte");
    rdc(OFF_DATA, 32'h22, "second byte");
    rdc(OFF_DATA, 32'h00, "empty buffer");
    PEER.send_async(8'h66, 1'b1);
    rdc(OFF_DATA, 32'h166, "frame error entry");
    apb(1'b0, OFF_STATUS, 32'h0, rd, eb);
    chk1(rd[ST_FE], 1'b1, "frame error event");
    wr(OFF_STATUS, 32'h3f);
    // Even parity: a zero parity slot is wrong for an odd count of ones
    wr(OFF_CTRL, 32'h70);
    PEER.send_async(8'h5b, 1'b1);
    rdc(OFF_DATA, 32'h25b, "parity error entry");
    rdc(OFF_STATUS, 32'h24, "parity events");
    wr(OFF_CTRL, 32'hf0);
    PEER.send_async(8'h5b, 1'b1);
    rdc(OFF_DATA, 32'h05b, "odd parity entry");
    wr(OFF_STATUS, 32'h3f);
    $display("test receive errors done");
    // Sync master: high divisor byte, pin driven at half the baud rate
    PEER.rx_on = 1'b0;
    set_div(12'h101);
    wr(OFF_CTRL, 32'h35);
    repeat (2) @(posedge sys_clk);
    chk1(xck_oe, 1'b1, "master drives pin");
    edge_gap(t0);
    for (int i = 0; i < 2; i++) begin
      edge_gap(t0);
      chk32(t0, 258, "master half period");
    end
    $display("test sync master done");
    // Sync slave, both polarities, both directions
    for (int p = 0; p < 2; p++) begin
      wr(OFF_CTRL, p ? 32'h39 : 32'h31);
      repeat (2) @(posedge sys_clk);
      chk1(xck_oe, 1'b0, "slave pin input");
      wr(OFF_DATA, p ? 32'h96 : 32'hc3);
      PEER.sync_xfer(p[0], 8'h5e, got);
      chk32({24'h0, got}, p ? 32'h96 : 32'hc3, "slave tx byte");
      rdc(OFF_DATA, 32'h5e, "slave rx byte");
      $display("test sync slave polarity %0d done", p);
    end
    test_done();
  end
endmodule
